/* File: rtl/flash_reset_params.svh */
// Timing constants and field positions for the flash reset sequencing ends
`ifndef FLASH_RESET_PARAMS_SVH
`define FLASH_RESET_PARAMS_SVH

// ------------------------------------------------------------
// Clock and timing figures
// ------------------------------------------------------------
`define SYS_CLK_MHZ 100
`define POWER_UP_INTERVAL_US 300
`define POWER_UP_CYC (`POWER_UP_INTERVAL_US * `SYS_CLK_MHZ)
`define RECOVERY_INTERVAL_US 35
`define RECOVERY_CYC (`RECOVERY_INTERVAL_US * `SYS_CLK_MHZ)
`define MIN_PULSE_WIDTH_NS 200
`define MIN_PULSE_CYC ((`MIN_PULSE_WIDTH_NS * `SYS_CLK_MHZ + 999) / 1000)
`define REARM_SETUP_TIME_NS 50
`define REARM_SETUP_CYC ((`REARM_SETUP_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define RELEASE_HOLD_TIME_NS 50
`define RELEASE_HOLD_CYC ((`RELEASE_HOLD_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define GUARD_READ_NS 10
`define GUARD_PROG_NS 50
`define GUARD_QUAD_RESET_NS 20
`define GUARD_READ_CYC ((`GUARD_READ_NS * `SYS_CLK_MHZ + 999) / 1000)
`define GUARD_PROG_CYC ((`GUARD_PROG_NS * `SYS_CLK_MHZ + 999) / 1000)
`define GUARD_QUAD_RESET_CYC ((`GUARD_QUAD_RESET_NS * `SYS_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------
// Volatile configuration bit positions and reset values
// ------------------------------------------------------------
`define CFG1_QUAD_BIT 1
`define CFG2_RESET_EN_BIT 5
`define CFG1_RESET_VAL 8'h00
`define CFG2_RESET_VAL 8'h20

`endif

/* File: rtl/flash_reset_pkg.sv */
// Types shared by the flash reset sequencing ends
package flash_reset_pkg;
    typedef enum logic [1:0] {
        CMD_NONE,
        CMD_READ,
        CMD_PROG
    } last_cmd_t;
endpackage

/* File: rtl/flash_reset_if.sv */
// Link between host and flash: select, serial clock and shared lane-3 pin
`timescale 1ns/1ps
`default_nettype none
interface flash_reset_if;
    logic cs_n;
    logic sclk;
    logic lane3_dev_o;
    logic lane3_dev_oe_n;
    logic lane3_host_o;
    logic lane3_host_oe_n;
    wire lane3_or_restart_pin;
    // Resolved pin level; internal pull-up keeps it high when nobody drives
    assign lane3_or_restart_pin = !lane3_dev_oe_n ? lane3_dev_o :
                                  !lane3_host_oe_n ? lane3_host_o : 1'b1;
    modport device (input cs_n, input sclk, input lane3_or_restart_pin,
                    output lane3_dev_o, output lane3_dev_oe_n);
    modport host (output cs_n, output sclk, input lane3_or_restart_pin,
                  output lane3_host_o, output lane3_host_oe_n);
endinterface
`default_nettype wire

/* File: rtl/flash_reset_device.sv */
// Flash end: power-up, warm reset, guard window and software reset
`timescale 1ns/1ps
`default_nettype none
`include "flash_reset_params.svh"
module flash_reset_device
    import flash_reset_pkg::*;
#(
    parameter int POWER_UP_CYC = `POWER_UP_CYC,
    parameter int RECOVERY_CYC = `RECOVERY_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    flash_reset_if.device link,
    // User side: core command decode reports
    input wire logic cmd_done,
    input wire logic cmd_quad_out,
    input wire logic cmd_was_prog,
    input wire logic soft_reset_cmd,
    input wire logic por_fault,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_one_in,
    input wire logic [7:0] cfg_two_in,
    // User side: status
    output logic por_busy,
    output logic hw_reset_busy,
    output logic soft_reset_pulse,
    output logic abort_pulse,
    output logic cmd_accept,
    output logic outputs_float,
    output logic [7:0] volatile_config_one,
    output logic [7:0] volatile_config_two
);
    typedef enum logic [1:0] {
        ST_POR,
        ST_RECOVER,
        ST_READY
    } dev_state_t;

    localparam int CNT_W = 32;
    // Recovery is timed from the pin's fall: two sync flops, the filter and the trigger
    localparam int RECOVER_LAST = RECOVERY_CYC - `MIN_PULSE_CYC - 4;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic cs_s1_r, cs_s2_r, pin_s1_r, pin_s2_r;
    // Two flops before any logic reads the link inputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= link.cs_n;
            cs_s2_r <= cs_s1_r;
            pin_s1_r <= link.lane3_or_restart_pin;
            pin_s2_r <= pin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Guard window and pin role
    // ------------------------------------------------------------
    dev_state_t state_r, state_nxt;
    last_cmd_t last_cmd_r;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [7:0] guard_cnt_r;
    logic [7:0] low_cnt_r;
    logic por_ok_r;
    wire quad_en = volatile_config_one[`CFG1_QUAD_BIT];
    wire reset_en = volatile_config_two[`CFG2_RESET_EN_BIT];
    wire [7:0] guard_len = (quad_en && reset_en) ? 8'(`GUARD_QUAD_RESET_CYC) :
                           (last_cmd_r == CMD_PROG) ? 8'(`GUARD_PROG_CYC) :
                           8'(`GUARD_READ_CYC);
    wire guard_over = guard_cnt_r >= guard_len;
    // With reset enabled, pin acts as reset only past the guard time, or always outside quad mode
    wire pin_is_reset = reset_en && (!quad_en || (cs_s2_r && guard_over));
    wire pin_low_valid = pin_is_reset && !pin_s2_r;
    wire pulse_ok = low_cnt_r >= 8'(`MIN_PULSE_CYC);
    wire hw_trigger = pulse_ok && pin_low_valid && (state_r == ST_READY);

    // Guard counter runs while select is high; quad with reset enabled sets its length, else the last command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            guard_cnt_r <= 8'h00;
            last_cmd_r <= CMD_NONE;
        end else begin
            if (!cs_s2_r)
                guard_cnt_r <= 8'h00;
            else if (!guard_over)
                guard_cnt_r <= guard_cnt_r + 8'h01;
            if (cmd_done)
                last_cmd_r <= cmd_was_prog ? CMD_PROG : CMD_READ;
        end
    end

    // Low-pulse width filter; restarts whenever the pin is not a valid low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            low_cnt_r <= 8'h00;
        else if (!pin_low_valid)
            low_cnt_r <= 8'h00;
        else if (!pulse_ok)
            low_cnt_r <= low_cnt_r + 8'h01;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state: power-up, warm recovery, ready
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_POR: begin
                // A reset still low as power-up ends keeps the flash in reset
                if (cnt_r >= CNT_W'(POWER_UP_CYC - 1) && pin_low_valid) begin
                    cnt_nxt = cnt_r;
                end else if (cnt_r >= CNT_W'(POWER_UP_CYC - 1)) begin
                    state_nxt = ST_READY;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_RECOVER: begin
                if (cnt_r >= CNT_W'(RECOVER_LAST)) begin
                    state_nxt = ST_READY;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_READY: begin
                if (hw_trigger) begin
                    // A failed power-up repeats the full power-up
                    state_nxt = por_ok_r ? ST_RECOVER : ST_POR;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = ST_POR;
                cnt_nxt = '0;
            end
        endcase
    end

    // State, power-up health and configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_POR;
            cnt_r <= '0;
            por_ok_r <= 1'b0;
            volatile_config_one <= `CFG1_RESET_VAL;
            volatile_config_two <= `CFG2_RESET_VAL;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (state_r == ST_POR && state_nxt == ST_READY)
                por_ok_r <= !por_fault;
            if (hw_trigger || soft_reset_cmd) begin
                volatile_config_one <= `CFG1_RESET_VAL;
                volatile_config_two <= `CFG2_RESET_VAL;
            end else if (cfg_write && state_r == ST_READY) begin
                volatile_config_one <= cfg_one_in;
                volatile_config_two <= cfg_two_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and pin drive
    // ------------------------------------------------------------
    logic drive_high_r;
    // Holds lane 3 high across the guard after a quad read
    // Released once the synced select has stood high past the guard, or when the flash leaves ready
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_high_r <= 1'b0;
            soft_reset_pulse <= 1'b0;
            abort_pulse <= 1'b0;
        end else begin
            if (cmd_done && cmd_quad_out && quad_en && state_r == ST_READY)
                drive_high_r <= 1'b1;
            else if ((cs_s2_r && guard_over) || state_r != ST_READY)
                drive_high_r <= 1'b0;
            soft_reset_pulse <= soft_reset_cmd;
            abort_pulse <= hw_trigger;
        end
    end

    assign por_busy = (state_r == ST_POR);
    assign hw_reset_busy = (state_r == ST_RECOVER);
    assign cmd_accept = (state_r == ST_READY) && !hw_trigger;
    assign outputs_float = (state_r != ST_READY);
    assign link.lane3_dev_o = 1'b1;
    assign link.lane3_dev_oe_n = !drive_high_r;
endmodule
`default_nettype wire

/* File: rtl/flash_reset_host.sv */
// Host end: select and shared pin sequencing around power-up and resets
`timescale 1ns/1ps
`default_nettype none
`include "flash_reset_params.svh"
module flash_reset_host
    import flash_reset_pkg::*;
#(
    parameter int POWER_UP_CYC = `POWER_UP_CYC,
    parameter int RECOVERY_CYC = `RECOVERY_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    flash_reset_if.host link,
    // User side
    input wire logic reset_req,
    input wire logic select_req,
    input wire logic last_was_write,
    output logic ready,
    output logic busy
);
    typedef enum logic [2:0] {
        H_POWER,
        H_IDLE,
        H_SELECT,
        H_GUARD,
        H_PULSE,
        H_HOLD
    } host_state_t;

    localparam int CNT_W = 32;
    localparam int PULSE_CYC = RECOVERY_CYC - `RELEASE_HOLD_CYC;

    host_state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic quad_write_r;
    wire cnt_hit_power = cnt_r >= CNT_W'(POWER_UP_CYC - 1);
    wire cnt_hit_pulse = cnt_r >= CNT_W'(PULSE_CYC - 1);
    wire cnt_hit_hold = cnt_r >= CNT_W'(`RELEASE_HOLD_CYC - 1);
    wire cnt_hit_rearm = cnt_r >= CNT_W'(`REARM_SETUP_CYC - 1);
    wire cnt_hit_guard = cnt_r >= CNT_W'(`GUARD_PROG_CYC - 1);

    // Next state of the host sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 1'b1;
        case (state_r)
            H_POWER: if (cnt_hit_power) begin
                state_nxt = H_IDLE;
                cnt_nxt = '0;
            end
            H_IDLE: begin
                if (reset_req && cnt_hit_rearm) begin
                    state_nxt = H_PULSE;
                    cnt_nxt = '0;
                end else if (select_req) begin
                    state_nxt = H_SELECT;
                    cnt_nxt = '0;
                end else if (cnt_hit_rearm) begin
                    cnt_nxt = cnt_r;
                end
            end
            H_SELECT: if (!select_req) begin
                state_nxt = H_GUARD;
                cnt_nxt = '0;
            end
            H_GUARD: if (cnt_hit_guard) begin
                state_nxt = H_IDLE;
                cnt_nxt = '0;
            end
            H_PULSE: if (cnt_hit_pulse) begin
                state_nxt = H_HOLD;
                cnt_nxt = '0;
            end
            H_HOLD: if (cnt_hit_hold) begin
                state_nxt = H_IDLE;
                cnt_nxt = '0;
            end
            default: begin
                state_nxt = H_POWER;
                cnt_nxt = '0;
            end
        endcase
    end

    // State register and write tracking for the guard drive
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= H_POWER;
            cnt_r <= '0;
            quad_write_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (state_r == H_SELECT)
                quad_write_r <= last_was_write;
        end
    end

    // Select is high except during a command; pin low only for the pulse
    assign link.cs_n = (state_r != H_SELECT);
    assign link.sclk = 1'b0;
    assign link.lane3_host_o = (state_r != H_PULSE);
    assign link.lane3_host_oe_n = !((state_r == H_PULSE) ||
                                    (state_r == H_GUARD && quad_write_r));
    assign ready = (state_r == H_IDLE);
    assign busy = (state_r != H_IDLE);
endmodule
`default_nettype wire

/* File: bench/flash_reset_properties.sv */
// Wire-level checks on the link between the flash end and the host end
`timescale 1ns/1ps
`default_nettype none
module flash_reset_properties #(
    parameter int POWER_UP_CYC = 200,
    parameter int RECOVERY_CYC = 100
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    input wire logic cs_n,
    input wire logic lane3_dev_o,
    input wire logic lane3_dev_oe_n,
    input wire logic lane3_host_oe_n,
    input wire logic lane3_or_restart_pin
);
    localparam int REARM_CYC = 5;
    int up_cnt_r;
    int hi_cnt_r;
    int lo_cnt_r;
    // Cycles since reset, and run lengths of the shared pin high and low
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt_r <= 0;
            hi_cnt_r <= 0;
            lo_cnt_r <= 0;
        end else begin
            up_cnt_r <= (up_cnt_r < POWER_UP_CYC) ? up_cnt_r + 1 : up_cnt_r;
            hi_cnt_r <= lane3_or_restart_pin ? hi_cnt_r + 1 : 0;
            lo_cnt_r <= lane3_or_restart_pin ? 0 : lo_cnt_r + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_pullup; lane3_dev_oe_n && lane3_host_oe_n |-> lane3_or_restart_pin; endproperty
    a_pullup: assert property (p_pullup) else $error("pin low with no driver");
    property p_quiet_power_up; up_cnt_r < POWER_UP_CYC |-> cs_n && lane3_host_oe_n; endproperty
    a_quiet_power_up: assert property (p_quiet_power_up)
        else $error("host active during power-up");
    property p_rearm; $fell(lane3_or_restart_pin) |-> hi_cnt_r >= REARM_CYC; endproperty
    a_rearm: assert property (p_rearm) else $error("reset pulse without rearm time");
    property p_pulse_sum; $rose(lane3_or_restart_pin) |-> lo_cnt_r + 5 >= RECOVERY_CYC; endproperty
    a_pulse_sum: assert property (p_pulse_sum) else $error("reset pulse too short");
    property p_hold; $rose(lane3_or_restart_pin) |-> cs_n [*5]; endproperty
    a_hold: assert property (p_hold) else $error("select low within hold time");
    property p_dev_high; !lane3_dev_oe_n |-> lane3_dev_o; endproperty
    a_dev_high: assert property (p_dev_high) else $error("flash drives lane low");
    property p_no_clash; !lane3_dev_oe_n |-> lane3_host_oe_n; endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive lane");
    property p_guard_drive;
        $fell(lane3_dev_oe_n) |-> !lane3_dev_oe_n [*2] ##[1:8] lane3_dev_oe_n;
    endproperty
    a_guard_drive: assert property (p_guard_drive) else $error("guard drive length");
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench joining the flash end and the host end
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import flash_reset_pkg::*;
    localparam int PU = 200;
    localparam int RC = 100;
    logic sys_clk = 0, rst_n = 0;
    logic cmd_done = 0, cmd_quad_out = 0, cmd_was_prog = 0, soft_reset_cmd = 0;
    logic por_fault = 0, cfg_write = 0, reset_req = 0, select_req = 0, last_was_write = 0;
    logic [7:0] cfg_one_in = 8'h00, cfg_two_in = 8'h20;
    logic por_busy, hw_reset_busy, soft_reset_pulse, abort_pulse, cmd_accept, outputs_float;
    logic [7:0] volatile_config_one, volatile_config_two;
    logic ready, busy;
    int fails = 0, comparisons = 0, cyc = 0, n, t0;
    flash_reset_if link();
    flash_reset_device #(.POWER_UP_CYC(PU), .RECOVERY_CYC(RC)) u_flash_reset_device (
        .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .cmd_done(cmd_done),
        .cmd_quad_out(cmd_quad_out), .cmd_was_prog(cmd_was_prog),
        .soft_reset_cmd(soft_reset_cmd), .por_fault(por_fault), .cfg_write(cfg_write),
        .cfg_one_in(cfg_one_in), .cfg_two_in(cfg_two_in), .por_busy(por_busy),
        .hw_reset_busy(hw_reset_busy), .soft_reset_pulse(soft_reset_pulse),
        .abort_pulse(abort_pulse), .cmd_accept(cmd_accept), .outputs_float(outputs_float),
        .volatile_config_one(volatile_config_one), .volatile_config_two(volatile_config_two));
    flash_reset_host #(.POWER_UP_CYC(PU), .RECOVERY_CYC(RC)) u_flash_reset_host (
        .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .reset_req(reset_req),
        .select_req(select_req), .last_was_write(last_was_write), .ready(ready), .busy(busy));
    flash_reset_properties #(.POWER_UP_CYC(PU), .RECOVERY_CYC(RC)) u_flash_reset_properties (
        .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(link.cs_n), .lane3_dev_o(link.lane3_dev_o),
        .lane3_dev_oe_n(link.lane3_dev_oe_n), .lane3_host_oe_n(link.lane3_host_oe_n),
        .lane3_or_restart_pin(link.lane3_or_restart_pin));
    // Clock and hang limit
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Count negedges until a signal reaches a level, bounded
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (s !== v && cnt < lim) begin
            @(negedge sys_clk);
            cnt++;
        end
    endtask
    task automatic cfg(input logic [7:0] one);
        @(posedge sys_clk);
        cfg_one_in <= one;
        cfg_write <= 1'b1;
        @(posedge sys_clk);
        cfg_write <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic power_up(input logic fault);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        por_fault <= fault;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check("por_busy", 8'h01, {7'h0, por_busy});
        check("cs_n", 8'h01, {7'h0, link.cs_n});
        check("cmd_accept", 8'h00, {7'h0, cmd_accept});
        check("config_one", 8'h00, volatile_config_one);
        check("config_two", 8'h20, volatile_config_two);
        wait_lvl(por_busy, 1'b0, PU + 50, n);
        check("power_up_long", 8'h01, {7'h0, n >= PU - 3 && n <= PU + 3});
        wait_lvl(ready, 1'b1, 20, n);
        check("idle_accept", 8'h01, {7'h0, cmd_accept});
        $display("test power_up done");
    endtask
    task automatic hw_reset();
        @(posedge sys_clk);
        reset_req <= 1'b1;
        // Mark the pin's fall; recovery is timed from it
        n = 0;
        while (link.lane3_or_restart_pin !== 1'b0 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        t0 = cyc;
        wait_lvl(abort_pulse, 1'b1, 60, n);
        check("abort_pulse", 8'h01, {7'h0, abort_pulse});
        check("pin_low", 8'h00, {7'h0, link.lane3_or_restart_pin});
        check("float", 8'h01, {7'h0, outputs_float});
        @(posedge sys_clk);
        reset_req <= 1'b0;
        @(negedge sys_clk);
        check("hw_busy", 8'h01, {7'h0, hw_reset_busy});
        check("blocked", 8'h00, {7'h0, cmd_accept});
        wait_lvl(hw_reset_busy, 1'b0, RC + 50, n);
        check("recovery_len", 8'h01, {7'h0, cyc - t0 >= RC - 3 && cyc - t0 <= RC});
        check("config_one", 8'h00, volatile_config_one);
        wait_lvl(ready, 1'b1, 30, n);
        $display("test hw_reset done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        power_up(1'b0);
        cfg(8'h02);
        check("config_one", 8'h02, volatile_config_one);
        hw_reset();
        // Quad read then deselect: flash holds lane high in the guard
        cfg(8'h02);
        @(posedge sys_clk);
        select_req <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cmd_done <= 1'b1;
        cmd_quad_out <= 1'b1;
        @(posedge sys_clk);
        cmd_done <= 1'b0;
        cmd_quad_out <= 1'b0;
        select_req <= 1'b0;
        wait_lvl(link.lane3_dev_oe_n, 1'b0, 20, n);
        check("guard_drive", 8'h00, {7'h0, link.lane3_dev_oe_n});
        check("guard_level", 8'h01, {7'h0, link.lane3_or_restart_pin});
        check("no_abort", 8'h00, {7'h0, abort_pulse});
        repeat (20) @(negedge sys_clk);
        $display("test guard done");
        // Software reset restores the volatile configuration
        @(posedge sys_clk);
        soft_reset_cmd <= 1'b1;
        @(posedge sys_clk);
        soft_reset_cmd <= 1'b0;
        wait_lvl(soft_reset_pulse, 1'b1, 5, n);
        check("soft_pulse", 8'h01, {7'h0, soft_reset_pulse});
        repeat (2) @(negedge sys_clk);
        check("soft_config", 8'h00, volatile_config_one);
        $display("test soft_reset done");
        // Faulty power-up turns the next pin reset into a full power-up
        power_up(1'b1);
        @(posedge sys_clk);
        por_fault <= 1'b0;
        reset_req <= 1'b1;
        wait_lvl(por_busy, 1'b1, 60, n);
        check("full_por", 8'h01, {7'h0, por_busy});
        @(posedge sys_clk);
        reset_req <= 1'b0;
        wait_lvl(por_busy, 1'b0, PU + 50, n);
        check("full_por_len", 8'h01, {7'h0, n >= PU - 3});
        $display("test por_fault done");
        test_done();
    end
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
